/* verilog/port_h_pkg.sv */
// Package with register map, field layout and carrier types for the port H GPIO block.
package port_h_pkg;

    localparam int          NUM_PINS     = 8;
    localparam int          NUM_EXT_IRQ  = 3;

    // Block base address and register offsets from it.
    localparam logic [31:0] BASE_ADDR    = 32'h4000_01c0;
    localparam logic [31:0] OFF_PIN_DATA = 32'h0000_0000;
    localparam logic [31:0] OFF_OUT_EN   = 32'h0000_0004;
    localparam logic [31:0] OFF_FUNC_SEL = 32'h0000_0008;
    localparam logic [31:0] OFF_IRQ_STAT = 32'h0000_0010;
    localparam logic [31:0] OFF_IRQ_CLR  = 32'h0000_0014;
    localparam logic [31:0] OFF_IRQ_EN   = 32'h0000_0018;
    localparam logic [31:0] OFF_OD_SEL   = 32'h0000_0028;
    localparam logic [31:0] OFF_PULL_UP  = 32'h0000_002c;
    localparam logic [31:0] OFF_PULL_DN  = 32'h0000_0030;
    localparam logic [31:0] OFF_IN_EN    = 32'h0000_0038;

    // Field positions: pin bits sit at 7..0, interrupt selects at 2..0.
    localparam int          PIN_LSB      = 0;
    localparam int          PIN_MSB      = 7;
    localparam int          IRQ_LSB      = 0;
    localparam int          IRQ_MSB      = 2;

    // Reset values.
    localparam logic [7:0]  RST_PINS     = 8'h00;
    localparam logic [2:0]  RST_IRQ      = 3'h0;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] in_en;
        logic [7:0] analog;
    } pad_ctrl_t;

endpackage : port_h_pkg

/* verilog/pin_sync.sv */
// Two-stage synchroniser for a vector of pad inputs.
`timescale 1ns/10ps
`default_nettype none
module pin_sync
    import port_h_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage feeds only the second so metastability cannot spread.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : pin_sync
`default_nettype wire

/* verilog/irq_sticky.sv */
// Sticky interrupt status with enable mask and write-one-to-clear.
`timescale 1ns/10ps
`default_nettype none
module irq_sticky
    import port_h_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_event,
    input  wire logic [2:0] i_clear,
    input  wire logic [2:0] i_enable,
    output logic      [2:0] o_status,
    output logic            o_irq
);
    logic [2:0] status_q;
    logic [2:0] status_d;

    // A new event beats a clear in the same cycle so no edge is lost.
    assign status_d = (status_q & ~i_clear) | i_event;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            status_q <= RST_IRQ;
        end else begin
            status_q <= status_d;
        end
    end

    assign o_status = status_q;
    assign o_irq    = |(status_q & i_enable);
endmodule : irq_sticky
`default_nettype wire

/* verilog/port_h_gpio.sv */
// Eight-pin GPIO port with external interrupt inputs and an APB register slave.
//
// Overview of operation
// - Eight pins, each independently input or output.
// - Pins also feed analog and interrupt inputs.
// - Reset clears all pin controls to disabled.
// - Selected enabled interrupt survives standby drive stop.
// - Outside standby, input enable alone passes interrupts.
// - Registers decoded at offsets from base address.
// - Data register: bits 7-0, upper read zero.
// - Output control bit enables pin driver.
// - Function bits 2-0 select interrupt inputs.
// - Open-drain bit: 0 push-pull, 1 open-drain.
// - Pull-up bit enables pull-up, upper zero.
// - Pull-down register at its own offset.
// - Input control register at its own offset.
// - Pull-down bits 7-0 enable pull-down.
// - Input bits 7-0 enable input buffer.
`timescale 1ns/10ps
`default_nettype none
module port_h_gpio
    import port_h_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire apb_req_t   i_apb,
    output apb_rsp_t        o_apb,
    input  wire logic [7:0] i_pin_in,
    input  wire logic       i_deep_standby,
    input  wire logic       i_standby_pin_drive_bit,
    output pad_ctrl_t       o_pad,
    output logic      [2:0] o_ext_irq,
    output logic            o_irq
);

    // Register hit test against the block base.
    function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] off);
        reg_hit = (addr == (BASE_ADDR + off));
    endfunction : reg_hit

    function automatic logic map_hit(input logic [31:0] addr);
        map_hit = reg_hit(addr, OFF_PIN_DATA) | reg_hit(addr, OFF_OUT_EN)
                | reg_hit(addr, OFF_FUNC_SEL) | reg_hit(addr, OFF_IRQ_STAT)
                | reg_hit(addr, OFF_IRQ_CLR)  | reg_hit(addr, OFF_IRQ_EN)
                | reg_hit(addr, OFF_OD_SEL)   | reg_hit(addr, OFF_PULL_UP)
                | reg_hit(addr, OFF_PULL_DN)  | reg_hit(addr, OFF_IN_EN);
    endfunction : map_hit

    logic [7:0]  pin_data_q;
    logic [7:0]  output_enable_q;
    logic [2:0]  function_select_q;
    logic [7:0]  open_drain_select_q;
    logic [7:0]  pull_up_enable_q;
    logic [7:0]  pull_down_enable_q;
    logic [7:0]  input_enable_q;
    logic [2:0]  irq_enable_q;
    logic [2:0]  irq_status;
    logic [2:0]  irq_clear;
    logic [7:0]  pin_sync_lvl;
    logic [7:0]  pin_read;
    logic [2:0]  ext_irq_q;
    logic [2:0]  ext_irq_d;
    logic [2:0]  ext_irq_prev_q;
    logic [31:0] prdata_q;
    logic        slverr_q;
    logic        setup;
    logic        wr_en;
    logic        drive_stop;
    pad_ctrl_t   pad_d;
    pad_ctrl_t   pad_q;

    // APB phases: the slave answers in the first access cycle.
    assign setup = i_apb.psel & ~i_apb.penable;
    assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite & map_hit(i_apb.paddr);

    pin_sync #(
        .WIDTH    (NUM_PINS)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n  (i_rst_n),
        .i_async  (i_pin_in),
        .o_sync   (pin_sync_lvl)
    );

    // Data latch holds what output pins drive.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pin_data_q <= RST_PINS;
        end else if (wr_en && reg_hit(i_apb.paddr, OFF_PIN_DATA)) begin
            pin_data_q <= i_apb.pwdata[PIN_MSB:PIN_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            output_enable_q <= RST_PINS;
        end else if (wr_en && reg_hit(i_apb.paddr, OFF_OUT_EN)) begin
            output_enable_q <= i_apb.pwdata[PIN_MSB:PIN_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            function_select_q <= RST_IRQ;
        end else if (wr_en && reg_hit(i_apb.paddr, OFF_FUNC_SEL)) begin
            function_select_q <= i_apb.pwdata[IRQ_MSB:IRQ_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            open_drain_select_q <= RST_PINS;
        end else if (wr_en && reg_hit(i_apb.paddr, OFF_OD_SEL)) begin
            open_drain_select_q <= i_apb.pwdata[PIN_MSB:PIN_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pull_up_enable_q <= RST_PINS;
        end else if (wr_en && reg_hit(i_apb.paddr, OFF_PULL_UP)) begin
            pull_up_enable_q <= i_apb.pwdata[PIN_MSB:PIN_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pull_down_enable_q <= RST_PINS;
        end else if (wr_en && reg_hit(i_apb.paddr, OFF_PULL_DN)) begin
            pull_down_enable_q <= i_apb.pwdata[PIN_MSB:PIN_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            input_enable_q <= RST_PINS;
        end else if (wr_en && reg_hit(i_apb.paddr, OFF_IN_EN)) begin
            input_enable_q <= i_apb.pwdata[PIN_MSB:PIN_LSB];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            irq_enable_q <= RST_IRQ;
        end else if (wr_en && reg_hit(i_apb.paddr, OFF_IRQ_EN)) begin
            irq_enable_q <= i_apb.pwdata[IRQ_MSB:IRQ_LSB];
        end
    end

    // The clear register stores nothing; a write is a one-cycle pulse.
    assign irq_clear = (wr_en && reg_hit(i_apb.paddr, OFF_IRQ_CLR))
                     ? i_apb.pwdata[IRQ_MSB:IRQ_LSB] : RST_IRQ;

    // Drivers are stopped only in deep standby with the stop bit set.
    assign drive_stop = i_deep_standby & i_standby_pin_drive_bit;

    // Per-pin pad control.
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pad
            always_comb begin
                pad_d.out[g]       = pin_data_q[g];
                // Open-drain pins drive only the low level and float the high.
                pad_d.oe[g]        = output_enable_q[g] & ~drive_stop
                                   & ~(open_drain_select_q[g] & pin_data_q[g]);
                pad_d.pull_up[g]   = pull_up_enable_q[g];
                pad_d.pull_down[g] = pull_down_enable_q[g];
                pad_d.in_en[g]     = input_enable_q[g];
                // A pin with neither buffer enabled is left to the converter.
                pad_d.analog[g]    = ~input_enable_q[g] & ~output_enable_q[g];
                pin_read[g]        = (input_enable_q[g] & ~output_enable_q[g])
                                   ? pin_sync_lvl[g] : pin_data_q[g];
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pad_q <= '0;
        end else begin
            pad_q <= pad_d;
        end
    end

    // External interrupt gating; the wake path needs the function select too.
    generate
        for (g = 0; g < NUM_EXT_IRQ; g++) begin : g_ext_irq
            always_comb begin
                if (i_deep_standby) begin
                    ext_irq_d[g] = input_enable_q[g] & function_select_q[g]
                                 & pin_sync_lvl[g];
                end else begin
                    // Input enable alone opens the path, so unused lines must stay off.
                    ext_irq_d[g] = input_enable_q[g] & pin_sync_lvl[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ext_irq_q      <= RST_IRQ;
            ext_irq_prev_q <= RST_IRQ;
        end else begin
            ext_irq_q      <= ext_irq_d;
            ext_irq_prev_q <= ext_irq_q;
        end
    end

    // Rising edges of the gated interrupt lines are the recorded events.
    irq_sticky u_irq_sticky (
        .i_sys_clk(i_sys_clk),
        .i_rst_n  (i_rst_n),
        .i_event  (ext_irq_q & ~ext_irq_prev_q),
        .i_clear  (irq_clear),
        .i_enable (irq_enable_q),
        .o_status (irq_status),
        .o_irq    (o_irq)
    );

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            prdata_q <= RST_WORD;
            slverr_q <= 1'b0;
        end else if (setup) begin
            slverr_q <= ~map_hit(i_apb.paddr);
            prdata_q <= RST_WORD;
            if (!i_apb.pwrite) begin
                if (reg_hit(i_apb.paddr, OFF_PIN_DATA)) begin
                    prdata_q <= {24'h00_0000, pin_read};
                end else if (reg_hit(i_apb.paddr, OFF_OUT_EN)) begin
                    prdata_q <= {24'h00_0000, output_enable_q};
                end else if (reg_hit(i_apb.paddr, OFF_FUNC_SEL)) begin
                    prdata_q <= {29'h0000_0000, function_select_q};
                end else if (reg_hit(i_apb.paddr, OFF_IRQ_STAT)) begin
                    prdata_q <= {29'h0000_0000, irq_status};
                end else if (reg_hit(i_apb.paddr, OFF_IRQ_EN)) begin
                    prdata_q <= {29'h0000_0000, irq_enable_q};
                end else if (reg_hit(i_apb.paddr, OFF_OD_SEL)) begin
                    prdata_q <= {24'h00_0000, open_drain_select_q};
                end else if (reg_hit(i_apb.paddr, OFF_PULL_UP)) begin
                    prdata_q <= {24'h00_0000, pull_up_enable_q};
                end else if (reg_hit(i_apb.paddr, OFF_PULL_DN)) begin
                    prdata_q <= {24'h00_0000, pull_down_enable_q};
                end else if (reg_hit(i_apb.paddr, OFF_IN_EN)) begin
                    prdata_q <= {24'h00_0000, input_enable_q};
                end
            end
        end
    end

    assign o_apb.prdata  = prdata_q;
    assign o_apb.pready  = 1'b1;
    assign o_apb.pslverr = slverr_q & i_apb.psel & i_apb.penable;
    assign o_pad         = pad_q;
    assign o_ext_irq     = ext_irq_q;

endmodule : port_h_gpio
`default_nettype wire

/* tb/port_h_gpio_properties.sv */
// Port-level assertions for the port H GPIO block.
`timescale 1ns/10ps
`default_nettype none
module port_h_gpio_properties
    import port_h_pkg::*;
(
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire apb_req_t   i_apb,
    input wire apb_rsp_t   o_apb,
    input wire logic [7:0] i_pin_in,
    input wire logic       i_deep_standby,
    input wire logic       i_standby_pin_drive_bit,
    input wire pad_ctrl_t  o_pad,
    input wire logic [2:0] o_ext_irq,
    input wire logic       o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire acc = i_apb.psel && i_apb.penable && o_apb.pready;

    a_reset_clear: assert property (disable iff (1'b0) !i_rst_n |=>
        o_pad == '0 && o_ext_irq == 3'h0 && !o_irq) else $error("outputs not cleared by reset");
    a_ready_access: assert property (i_apb.psel && i_apb.penable |-> o_apb.pready)
        else $error("access phase not answered");
    a_slverr_phase: assert property (o_apb.pslverr |-> i_apb.psel && i_apb.penable)
        else $error("error response outside access phase");
    a_unmapped_err: assert property (acc && i_apb.paddr == BASE_ADDR + 32'h20 |-> o_apb.pslverr)
        else $error("unmapped access without error");
    a_upper_zero: assert property (acc && !i_apb.pwrite |-> o_apb.prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_pullup_write: assert property (acc && i_apb.pwrite && i_apb.paddr == BASE_ADDR + 32'h2c
        |-> ##2 o_pad.pull_up == $past(i_apb.pwdata[7:0], 2)) else $error("pull-up pad wrong");
    a_inen_write: assert property (acc && i_apb.pwrite && i_apb.paddr == BASE_ADDR + 32'h38
        |-> ##2 o_pad.in_en == $past(i_apb.pwdata[7:0], 2)) else $error("input enable pad wrong");
    a_irq_gated: assert property ((o_pad.in_en[2:0] == 3'h0) [*2] |-> o_ext_irq == 3'h0)
        else $error("interrupt passed with input disabled");
    // The pin level reaches the gated line three edges later, through two sync stages.
    a_irq_cause: assert property ($rose(o_ext_irq[0]) |-> $past(i_pin_in[0], 3))
        else $error("interrupt rose without pin level");
    a_analog_idle: assert property ((o_pad.analog & (o_pad.in_en | o_pad.oe)) == 8'h0)
        else $error("analog selected on a used pin");
endmodule : port_h_gpio_properties

bind port_h_gpio port_h_gpio_properties u_props (.i_sys_clk, .i_rst_n, .i_apb, .o_apb,
    .i_pin_in, .i_deep_standby, .i_standby_pin_drive_bit, .o_pad, .o_ext_irq, .o_irq);
`default_nettype wire

/* tb/port_h_pins.sv */
// Model of the board side of the eight port pins.
`timescale 1ns/10ps
`default_nettype none
module port_h_pins
    import port_h_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire pad_ctrl_t  i_pad,
    input  wire logic [7:0] i_ext_val,
    input  wire logic [7:0] i_ext_drv,
    output logic      [7:0] o_pin
);
    logic [7:0] float_q = 8'h00;
    // A pin nobody holds has no defined level, so it changes every cycle.
    always @(posedge i_sys_clk) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_pad.oe[i]) o_pin[i] = i_pad.out[i];
            else if (i_ext_drv[i]) o_pin[i] = i_ext_val[i];
            else if (i_pad.pull_up[i]) o_pin[i] = 1'b1;
            else if (i_pad.pull_down[i]) o_pin[i] = 1'b0;
            else o_pin[i] = float_q[i];
        end
    end
endmodule : port_h_pins
`default_nettype wire

/* tb/port_h_gpio_tb.sv */
// Self-checking bench for the port H GPIO block.
`timescale 1ns/10ps
`default_nettype none
module port_h_gpio_tb
    import port_h_pkg::*;
;
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n   = 1'b0;
    apb_req_t    req       = '0;
    apb_rsp_t    rsp;
    logic [7:0]  pin;
    logic        stby      = 1'b0;
    logic        stop      = 1'b0;
    logic [7:0]  ext_val   = 8'h00;
    logic [7:0]  ext_drv   = 8'h00;
    pad_ctrl_t   pad;
    logic [2:0]  ext_irq;
    logic        irq;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc       = 0;
    logic [31:0] offs [10] = '{32'h00, 32'h04, 32'h08, 32'h28, 32'h2c, 32'h30, 32'h38,
                               32'h18, 32'h10, 32'h14};
    logic [31:0] mask [8]  = '{32'hff, 32'hff, 32'h07, 32'hff, 32'hff, 32'hff, 32'hff, 32'h07};

    port_h_gpio dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_apb(req), .o_apb(rsp),
        .i_pin_in(pin), .i_deep_standby(stby), .i_standby_pin_drive_bit(stop), .o_pad(pad),
        .o_ext_irq(ext_irq), .o_irq(irq));
    port_h_pins pins (.i_sys_clk(i_sys_clk), .i_pad(pad), .i_ext_val(ext_val),
        .i_ext_drv(ext_drv), .o_pin(pin));

    always begin
        #12.5 i_sys_clk = ~i_sys_clk;
    end

    task automatic print_verdict();
        if (err_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // The ceiling sits well above the few hundred cycles the sequence needs.
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge i_sys_clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= BASE_ADDR + a;
        req.pwdata  <= d;
        @(posedge i_sys_clk);
        req.penable <= 1'b1;
        do @(posedge i_sys_clk); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rd

    initial begin
        logic [31:0] r;
        logic        e;
        repeat (6) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        chk(32'(pad !== '0), 32'h0);
        for (int i = 0; i < 10; i++) rd(offs[i], 32'h0);
        ext_drv <= 8'hff;
        for (int i = 0; i < 8; i++) begin
            wr(offs[i], 32'hffff_ffff);
            rd(offs[i], mask[i]);
        end
        chk({8'h0, pad.pull_up, pad.pull_down, pad.in_en}, 32'h00ff_ffff);
        chk(32'(pad.oe), 32'h0);
        for (int i = 0; i < 8; i++) wr(offs[i], 32'h0);
        apb(1'b0, 32'h20, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        wr(32'h00, 32'ha5);
        wr(32'h04, 32'hff);
        repeat (2) @(posedge i_sys_clk);
        chk({16'h0, pad.out, pad.oe}, 32'ha5ff);
        rd(32'h00, 32'ha5);
        wr(32'h28, 32'h01);
        repeat (2) @(posedge i_sys_clk);
        chk(32'(pad.oe), 32'hfe);
        wr(32'h00, 32'ha4);
        repeat (2) @(posedge i_sys_clk);
        chk(32'(pad.oe), 32'hff);
        wr(32'h28, 32'h0);
        wr(32'h04, 32'h0);
        wr(32'h38, 32'hff);
        ext_val <= 8'h3c;
        repeat (4) @(posedge i_sys_clk);
        rd(32'h00, 32'h3c);
        ext_val <= 8'h00;
        wr(32'h38, 32'h01);
        wr(32'h14, 32'h07);
        wr(32'h18, 32'h01);
        ext_val <= 8'h01;
        repeat (6) @(posedge i_sys_clk);
        chk(32'(irq), 32'h1);
        rd(32'h10, 32'h1);
        wr(32'h14, 32'h01);
        rd(32'h10, 32'h0);
        chk(32'(irq), 32'h0);
        ext_val <= 8'h00;
        repeat (4) @(posedge i_sys_clk);
        wr(32'h18, 32'h0);
        ext_val <= 8'h01;
        repeat (6) @(posedge i_sys_clk);
        chk(32'(irq), 32'h0);
        rd(32'h10, 32'h1);
        wr(32'h18, 32'h01);
        @(posedge i_sys_clk);
        chk(32'(irq), 32'h1);
        wr(32'h14, 32'h01);
        stby <= 1'b1;
        stop <= 1'b1;
        wr(32'h38, 32'h02);
        ext_val <= 8'h03;
        repeat (6) @(posedge i_sys_clk);
        chk(32'(ext_irq), 32'h0);
        wr(32'h08, 32'h02);
        repeat (3) @(posedge i_sys_clk);
        chk(32'(ext_irq), 32'h2);
        stby <= 1'b0;
        wr(32'h08, 32'h0);
        repeat (3) @(posedge i_sys_clk);
        chk(32'(ext_irq), 32'h2);
        wr(32'h38, 32'h0);
        // A second reset in mid-run must bring every control back to its idle value.
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        chk(32'(pad !== '0), 32'h0);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(offs[i], 32'h0);
        chk(32'(pad.analog), 32'hff);
        print_verdict();
    end
endmodule : port_h_gpio_tb
`default_nettype wire
